// ---- src/gpfs_pkg.sv ----
// constants for the nine-pin port unit with pin function select
package gpfs_pkg;

	// register byte addresses
	localparam logic [31:0] CON0_ADDR = 32'hFFFF0D00;
	localparam logic [31:0] CON1_ADDR = 32'hFFFF0D04;
	localparam logic [31:0] CON2_ADDR = 32'hFFFF0D08;
	localparam logic [31:0] DAT0_ADDR = 32'hFFFF0D20;
	localparam logic [31:0] DAT1_ADDR = 32'hFFFF0D30;
	localparam logic [31:0] DAT2_ADDR = 32'hFFFF0D40;
	localparam logic [31:0] SET_OFS   = 32'h00000004;
	localparam logic [31:0] CLR_OFS   = 32'h00000008;

	// reset values of the function select registers
	localparam logic [31:0] CON0_RESET = 32'h11100000;
	localparam logic [31:0] CON1_RESET = 32'h10000000;
	localparam logic [31:0] CON2_RESET = 32'h01000000;

	// port 0 function select bits
	localparam int CON0_SS_BIT   = 0;
	localparam int CON0_SCLK_BIT = 4;
	localparam int CON0_MISO_BIT = 8;
	localparam int CON0_MOSI_BIT = 12;
	localparam int CON0_FCLK_BIT = 16;
	localparam int CON0_HV5_BIT  = 20;
	localparam int CON0_HV6_BIT  = 24;
	// port 1 function select bits
	localparam int CON1_RX_BIT = 0;
	localparam int CON1_TX_BIT = 4;
	// port 2 routing of the serial test data
	localparam int CON2_TEST_BIT = 24;

	// data register fields: readback, output data, direction
	localparam int DAT_IN_LSB  = 0;
	localparam int DAT_OUT_LSB = 8;
	localparam int DAT_DIR_LSB = 16;
	localparam int DAT_FIELD_W = 8;

	// port widths, internal signals included
	localparam int PORT0_W = 7;
	localparam int PORT1_W = 2;
	localparam int PORT2_W = 7;

	// fixed clock output
	localparam int CORE_CLK_KHZ  = 25000;
	localparam int FIXED_CLK_KHZ = 2560;
	localparam int FIXED_ACC_W   = 15;

endpackage : gpfs_pkg

// ---- src/gpfs_port_if.sv ----
// register strobes and pin drive of one port, between the top and a port slice
`timescale 1ns/1ps
`default_nettype none
interface gpfs_port_if #(
	parameter int W = 2
);
	logic         wr_dat;
	logic         wr_set;
	logic         wr_clr;
	logic [31:0]  wdata;
	logic [W-1:0] alt_sel;
	logic [W-1:0] alt_out;
	logic [W-1:0] alt_oe;
	logic         hold;
	logic [W-1:0] dir;
	logic [W-1:0] data;
	logic [W-1:0] drv_out;
	logic [W-1:0] drv_oe;

	modport slice (
		input  wr_dat, wr_set, wr_clr, wdata, alt_sel, alt_out, alt_oe, hold,
		output dir, data, drv_out, drv_oe
	);
	modport ctrl (
		output wr_dat, wr_set, wr_clr, wdata, alt_sel, alt_out, alt_oe, hold,
		input  dir, data, drv_out, drv_oe
	);
endinterface : gpfs_port_if
`default_nettype wire

// ---- src/gpfs_port_slice.sv ----
// one port: direction and data registers, set and clear, pin drive mux
`timescale 1ns/1ps
`default_nettype none
module gpfs_port_slice #(
	parameter int W = 2
) (
	input  wire logic  clk_in,
	input  wire logic  rst_n_in,
	input  wire logic  ce_in,
	gpfs_port_if.slice port
);

	typedef struct packed {
		logic [W-1:0] dir;
		logic [W-1:0] data;
		logic [W-1:0] drv_out;
		logic [W-1:0] drv_oe;
	} gpfs_slice_s;

	gpfs_slice_s state;
	gpfs_slice_s next_state;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		if (port.wr_dat) begin
			next_state.dir  = port.wdata[gpfs_pkg::DAT_DIR_LSB +: W];
			next_state.data = port.wdata[gpfs_pkg::DAT_OUT_LSB +: W];
		end
		if (port.wr_set) begin
			next_state.data = state.data | port.wdata[gpfs_pkg::DAT_OUT_LSB +: W];
		end
		if (port.wr_clr) begin
			next_state.data = state.data & ~port.wdata[gpfs_pkg::DAT_OUT_LSB +: W];
		end
		// in power-down the pins keep the level they had
		if (!port.hold) begin
			for (int i = 0; i < W; i++) begin
				if (port.alt_sel[i]) begin
					next_state.drv_out[i] = port.alt_out[i];
					next_state.drv_oe[i]  = port.alt_oe[i];
				end else begin
					next_state.drv_out[i] = next_state.data[i];
					next_state.drv_oe[i]  = next_state.dir[i];
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= '0;
		end else if (ce_in) begin
			state <= next_state;
		end
	end

	assign port.dir     = state.dir;
	assign port.data    = state.data;
	assign port.drv_out = state.drv_out;
	assign port.drv_oe  = state.drv_oe;

endmodule : gpfs_port_slice
`default_nettype wire

// ---- src/gpfs_fixed_clk.sv ----
// fractional divider that makes the fixed clock output from the core clock
`timescale 1ns/1ps
`default_nettype none
module gpfs_fixed_clk #(
	parameter int CORE_KHZ  = gpfs_pkg::CORE_CLK_KHZ,
	parameter int OUT_KHZ   = gpfs_pkg::FIXED_CLK_KHZ,
	parameter int ACC_W     = gpfs_pkg::FIXED_ACC_W
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	input  wire logic enable_in,
	output logic      clk_out
);

	// two toggles per output period; jitter of one core cycle is the price of a non-integer ratio
	localparam logic [ACC_W-1:0] STEP = ACC_W'(2 * OUT_KHZ);
	localparam logic [ACC_W-1:0] WRAP = ACC_W'(CORE_KHZ);

	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic             level;
	} gpfs_clk_s;

	gpfs_clk_s state;
	gpfs_clk_s next_state;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		if (!enable_in) begin
			next_state = '0;
		end else if (state.acc >= WRAP - STEP) begin
			next_state.acc   = state.acc + STEP - WRAP;
			next_state.level = ~state.level;
		end else begin
			next_state.acc = state.acc + STEP;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= '0;
		end else if (ce_in) begin
			state <= next_state;
		end
	end

	assign clk_out = state.level;

endmodule : gpfs_fixed_clk
`default_nettype wire

// ---- src/gpfs_top.sv ----
// nine-pin port unit: function select registers, pin muxing, external interrupt levels
`timescale 1ns/1ps
`default_nettype none
module gpfs_top (
	input  wire logic        MCLK_IN,
	input  wire logic        RST_N_IN,
	input  wire logic        CE_IN,
	input  wire logic [31:0] ADDR_IN,
	input  wire logic [31:0] WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic      [31:0] RDATA_OUT,
	input  wire logic        POWER_DOWN_IN,
	input  wire logic [8:0]  GPIO_IN,
	output logic      [8:0]  GPIO_OUT,
	output logic      [8:0]  GPIO_OE_N_OUT,
	input  wire logic [3:0]  SPI_DRV_IN,
	input  wire logic [3:0]  SPI_DRV_EN_IN,
	output logic      [3:0]  SPI_PIN_OUT,
	input  wire logic        UART_TX_IN,
	output logic             UART_RX_OUT,
	output logic      [3:0]  EXT_IRQ_OUT,
	output logic      [1:0]  HV_LINK_OUT,
	input  wire logic [1:0]  HV_LINK_IN,
	input  wire logic        TEST_DATA_IN,
	output logic             TEST_DATA_OUT,
	output logic             DIAG_WRITE_OUT,
	input  wire logic        DIAG_READ_IN,
	output logic             FIXED_CLK_OUT
);

	localparam int W0 = gpfs_pkg::PORT0_W;
	localparam int W1 = gpfs_pkg::PORT1_W;
	localparam int W2 = gpfs_pkg::PORT2_W;

	typedef struct packed {
		logic [31:0] con0;
		logic [31:0] con1;
		logic [31:0] con2;
		logic [31:0] rdata;
		logic [3:0]  irq;
	} gpfs_top_s;

	gpfs_top_s state;
	gpfs_top_s next_state;

	gpfs_port_if #(.W(W0)) p0 ();
	gpfs_port_if #(.W(W1)) p1 ();
	gpfs_port_if #(.W(W2)) p2 ();

	logic          fixed_clk;
	logic [W0-1:0] pin0;
	logic [W1-1:0] pin1;
	logic [W2-1:0] pin2;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] dat_word(input logic [7:0] dir, input logic [7:0] dout, input logic [7:0] din);
		dat_word = {8'h00, dir, dout, din};
	endfunction : dat_word

	function automatic logic hit(input logic [31:0] addr, input logic [31:0] target);
		hit = (addr == target);
	endfunction : hit

	////////////////////////////////////////////////////////////////////////////
	// pin levels seen by each port, internal signals included

	assign pin0 = {HV_LINK_IN, GPIO_IN[4:0]};
	assign pin1 = GPIO_IN[6:5];
	// 2.2 and 2.3 do not exist; 2.5 and 2.6 read back their own drive
	assign pin2 = {p2.drv_out[6], p2.drv_out[5], DIAG_READ_IN, 2'b00, GPIO_IN[8:7]};

	////////////////////////////////////////////////////////////////////////////
	// register strobes into the port slices

	assign p0.wr_dat = WR_IN && hit(ADDR_IN, gpfs_pkg::DAT0_ADDR);
	assign p0.wr_set = WR_IN && hit(ADDR_IN, gpfs_pkg::DAT0_ADDR + gpfs_pkg::SET_OFS);
	assign p0.wr_clr = WR_IN && hit(ADDR_IN, gpfs_pkg::DAT0_ADDR + gpfs_pkg::CLR_OFS);
	assign p1.wr_dat = WR_IN && hit(ADDR_IN, gpfs_pkg::DAT1_ADDR);
	assign p1.wr_set = WR_IN && hit(ADDR_IN, gpfs_pkg::DAT1_ADDR + gpfs_pkg::SET_OFS);
	assign p1.wr_clr = WR_IN && hit(ADDR_IN, gpfs_pkg::DAT1_ADDR + gpfs_pkg::CLR_OFS);
	assign p2.wr_dat = WR_IN && hit(ADDR_IN, gpfs_pkg::DAT2_ADDR);
	assign p2.wr_set = WR_IN && hit(ADDR_IN, gpfs_pkg::DAT2_ADDR + gpfs_pkg::SET_OFS);
	assign p2.wr_clr = WR_IN && hit(ADDR_IN, gpfs_pkg::DAT2_ADDR + gpfs_pkg::CLR_OFS);
	assign p0.wdata  = WDATA_IN;
	assign p1.wdata  = WDATA_IN;
	assign p2.wdata  = WDATA_IN;
	assign p0.hold   = POWER_DOWN_IN;
	assign p1.hold   = POWER_DOWN_IN;
	assign p2.hold   = POWER_DOWN_IN;

	////////////////////////////////////////////////////////////////////////////
	// alternate functions; a clear select bit leaves the pin as plain I/O

	assign p0.alt_sel = {2'b00,
		state.con0[gpfs_pkg::CON0_FCLK_BIT],
		state.con0[gpfs_pkg::CON0_MOSI_BIT],
		state.con0[gpfs_pkg::CON0_MISO_BIT],
		state.con0[gpfs_pkg::CON0_SCLK_BIT],
		state.con0[gpfs_pkg::CON0_SS_BIT]};
	assign p0.alt_out = {2'b00, fixed_clk, SPI_DRV_IN};
	assign p0.alt_oe  = {2'b00, 1'b1, SPI_DRV_EN_IN};

	assign p1.alt_sel = {state.con1[gpfs_pkg::CON1_TX_BIT], state.con1[gpfs_pkg::CON1_RX_BIT]};
	// receive pin is never driven while it belongs to the UART
	assign p1.alt_out = {UART_TX_IN, 1'b0};
	assign p1.alt_oe  = {1'b1, 1'b0};

	assign p2.alt_sel = {state.con2[gpfs_pkg::CON2_TEST_BIT], 6'b000000};
	assign p2.alt_out = {TEST_DATA_IN, 6'b000000};
	assign p2.alt_oe  = {1'b1, 6'b000000};

	////////////////////////////////////////////////////////////////////////////
	// slices and clock source

	gpfs_port_slice #(.W(W0)) u_port0 (
		.clk_in   (MCLK_IN),
		.rst_n_in (RST_N_IN),
		.ce_in    (CE_IN),
		.port     (p0.slice)
	);

	gpfs_port_slice #(.W(W1)) u_port1 (
		.clk_in   (MCLK_IN),
		.rst_n_in (RST_N_IN),
		.ce_in    (CE_IN),
		.port     (p1.slice)
	);

	gpfs_port_slice #(.W(W2)) u_port2 (
		.clk_in   (MCLK_IN),
		.rst_n_in (RST_N_IN),
		.ce_in    (CE_IN),
		.port     (p2.slice)
	);

	gpfs_fixed_clk u_fixed_clk (
		.clk_in    (MCLK_IN),
		.rst_n_in  (RST_N_IN),
		.ce_in     (CE_IN),
		.enable_in (state.con0[gpfs_pkg::CON0_FCLK_BIT]),
		.clk_out   (fixed_clk)
	);

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_comb begin
		next_state       = state;
		next_state.rdata = 32'h00000000;
		// interrupt levels follow the pins, not latched, one cycle of delay
		next_state.irq   = {GPIO_IN[8], GPIO_IN[7], GPIO_IN[5], GPIO_IN[0]};
		if (WR_IN) begin
			if (hit(ADDR_IN, gpfs_pkg::CON0_ADDR)) begin
				next_state.con0 = WDATA_IN;
			end
			if (hit(ADDR_IN, gpfs_pkg::CON1_ADDR)) begin
				next_state.con1 = WDATA_IN;
			end
			if (hit(ADDR_IN, gpfs_pkg::CON2_ADDR)) begin
				next_state.con2 = WDATA_IN;
			end
		end
		if (RD_IN) begin
			case (ADDR_IN)
				gpfs_pkg::CON0_ADDR: next_state.rdata = state.con0;
				gpfs_pkg::CON1_ADDR: next_state.rdata = state.con1;
				gpfs_pkg::CON2_ADDR: next_state.rdata = state.con2;
				gpfs_pkg::DAT0_ADDR: next_state.rdata = dat_word({1'b0, p0.dir}, {1'b0, p0.data}, {1'b0, pin0});
				gpfs_pkg::DAT1_ADDR: next_state.rdata = dat_word({6'h00, p1.dir}, {6'h00, p1.data}, {6'h00, pin1});
				gpfs_pkg::DAT2_ADDR: next_state.rdata = dat_word({1'b0, p2.dir}, {1'b0, p2.data}, {1'b0, pin2});
				default:             next_state.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state.con0  <= gpfs_pkg::CON0_RESET;
			state.con1  <= gpfs_pkg::CON1_RESET;
			state.con2  <= gpfs_pkg::CON2_RESET;
			state.rdata <= 32'h00000000;
			state.irq   <= 4'h0;
		end else if (CE_IN) begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign RDATA_OUT      = state.rdata;
	assign EXT_IRQ_OUT    = state.irq;
	assign GPIO_OUT       = {p2.drv_out[1:0], p1.drv_out, p0.drv_out[4:0]};
	assign GPIO_OE_N_OUT  = ~{p2.drv_oe[1:0], p1.drv_oe, p0.drv_oe[4:0]};
	assign SPI_PIN_OUT    = GPIO_IN[3:0];
	assign UART_RX_OUT    = state.con1[gpfs_pkg::CON1_RX_BIT] ? GPIO_IN[5] : 1'b1;
	// link lines run only while their con0 select bits are set, as they are from reset
	assign HV_LINK_OUT[0] = p0.drv_out[5] & state.con0[gpfs_pkg::CON0_HV5_BIT];
	assign HV_LINK_OUT[1] = p0.drv_out[6] & state.con0[gpfs_pkg::CON0_HV6_BIT];
	assign TEST_DATA_OUT  = p2.drv_out[6];
	assign DIAG_WRITE_OUT = p2.drv_out[5];
	assign FIXED_CLK_OUT  = fixed_clk;

endmodule : gpfs_top
`default_nettype wire

// ---- dv/gpfs_pin_model.sv ----
// far side of the pins: pull-ups, outside drivers, spi and uart peripherals
`timescale 1ns/1ps
`default_nettype none
module gpfs_pin_model (
	input  wire logic       clk_in,
	input  wire logic [8:0] drv_in,
	input  wire logic [8:0] oe_n_in,
	input  wire logic [8:0] ext_en_in,
	input  wire logic [8:0] ext_val_in,
	output logic      [8:0] pin_out,
	output logic      [3:0] spi_drv_out,
	output logic      [3:0] spi_en_out,
	output logic            tx_out
);
	logic [7:0] cnt = 8'h00;
	// every pin has a pull-up, so a released pin reads high, never the last value
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			pin_out[i] = !oe_n_in[i] ? drv_in[i] : (ext_en_in[i] ? ext_val_in[i] : 1'b1);
		end
	end
	always_ff @(posedge clk_in) begin
		cnt <= cnt + 8'h01;
	end
	assign spi_drv_out = cnt[3:0] ^ cnt[7:4];
	assign spi_en_out  = cnt[7:4];
	assign tx_out      = cnt[1];
endmodule : gpfs_pin_model
`default_nettype wire

// ---- dv/gpfs_monitor.sv ----
// checker of pin muxing, hold and bus idle, bound to the port unit top
`timescale 1ns/1ps
`default_nettype none
module gpfs_monitor (
	input wire logic        MCLK_IN,
	input wire logic        RST_N_IN,
	input wire logic        CE_IN,
	input wire logic [31:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic        WR_IN,
	input wire logic        RD_IN,
	input wire logic [31:0] RDATA_OUT,
	input wire logic        POWER_DOWN_IN,
	input wire logic [8:0]  GPIO_IN,
	input wire logic [8:0]  GPIO_OUT,
	input wire logic [8:0]  GPIO_OE_N_OUT,
	input wire logic [3:0]  SPI_DRV_IN,
	input wire logic [3:0]  SPI_DRV_EN_IN,
	input wire logic        UART_TX_IN,
	input wire logic        UART_RX_OUT,
	input wire logic [3:0]  EXT_IRQ_OUT,
	input wire logic [1:0]  HV_LINK_OUT,
	input wire logic        FIXED_CLK_OUT
);
	logic [31:0] con0q;
	logic [31:0] con1q;
	logic [3:0]  irq_src;
	assign irq_src = {GPIO_IN[8], GPIO_IN[7], GPIO_IN[5], GPIO_IN[0]};
	// shadow of select registers 0 and 1, so pin checks follow software writes
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			con0q <= gpfs_pkg::CON0_RESET;
			con1q <= gpfs_pkg::CON1_RESET;
		end else if (CE_IN && WR_IN) begin
			if (ADDR_IN == gpfs_pkg::CON0_ADDR) con0q <= WDATA_IN;
			if (ADDR_IN == gpfs_pkg::CON1_ADDR) con1q <= WDATA_IN;
		end
	end
	////////////////////////////////////////
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	sequence run_s(sel);
		sel && CE_IN && !POWER_DOWN_IN;
	endsequence
	sequence off_s(sel);
		!sel ##1 !sel;
	endsequence
	property clk_pin_p;
		run_s(con0q[16]) |=> GPIO_OUT[4] == $past(FIXED_CLK_OUT) && !GPIO_OE_N_OUT[4];
	endproperty
	property spi_p(int b);
		run_s(con0q[4*b]) |=> GPIO_OUT[b] == $past(SPI_DRV_IN[b]) && GPIO_OE_N_OUT[b] == !$past(SPI_DRV_EN_IN[b]);
	endproperty
	rst_mode_a: assert property ($rose(RST_N_IN) |-> GPIO_OE_N_OUT == 9'h1FF && !FIXED_CLK_OUT)
		else $error("pins driven after reset");
	irq_level_a: assert property (CE_IN |=> EXT_IRQ_OUT == $past(irq_src))
		else $error("interrupt level wrong");
	bus_idle_a: assert property (CE_IN && !RD_IN |=> RDATA_OUT == 32'h00000000)
		else $error("read data not idle");
	for (genvar b = 0; b < 4; b++) begin : g_spi
		spi_mux_a: assert property (spi_p(b)) else $error("spi pin drive wrong");
	end
	rx_route_a: assert property (UART_RX_OUT == (con1q[0] ? GPIO_IN[5] : 1'b1))
		else $error("uart receive route wrong");
	tx_mux_a: assert property (run_s(con1q[4]) |=> GPIO_OUT[6] == $past(UART_TX_IN) && !GPIO_OE_N_OUT[6])
		else $error("uart transmit drive wrong");
	clk_off_a: assert property (off_s(con0q[16]) |-> !FIXED_CLK_OUT)
		else $error("fixed clock runs while off");
	clk_pin_a: assert property (clk_pin_p) else $error("fixed clock not on its pin");
	pd_hold_a: assert property (POWER_DOWN_IN || !CE_IN |=> $stable(GPIO_OUT) && $stable(GPIO_OE_N_OUT))
		else $error("pin drive moved in hold");
	hv5_gate_a: assert property (off_s(con0q[20]) |-> !HV_LINK_OUT[0])
		else $error("link line 0 not gated");
	hv6_gate_a: assert property (off_s(con0q[24]) |-> !HV_LINK_OUT[1])
		else $error("link line 1 not gated");
endmodule : gpfs_monitor
bind gpfs_top gpfs_monitor u_mon (
	.MCLK_IN       (MCLK_IN),
	.RST_N_IN      (RST_N_IN),
	.CE_IN         (CE_IN),
	.ADDR_IN       (ADDR_IN),
	.WDATA_IN      (WDATA_IN),
	.WR_IN         (WR_IN),
	.RD_IN         (RD_IN),
	.RDATA_OUT     (RDATA_OUT),
	.POWER_DOWN_IN (POWER_DOWN_IN),
	.GPIO_IN       (GPIO_IN),
	.GPIO_OUT      (GPIO_OUT),
	.GPIO_OE_N_OUT (GPIO_OE_N_OUT),
	.SPI_DRV_IN    (SPI_DRV_IN),
	.SPI_DRV_EN_IN (SPI_DRV_EN_IN),
	.UART_TX_IN    (UART_TX_IN),
	.UART_RX_OUT   (UART_RX_OUT),
	.EXT_IRQ_OUT   (EXT_IRQ_OUT),
	.HV_LINK_OUT   (HV_LINK_OUT),
	.FIXED_CLK_OUT (FIXED_CLK_OUT)
);
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the nine-pin port unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ce = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        pd = 1'b0;
	logic        tdat = 1'b0;
	logic        dread = 1'b0;
	logic [31:0] addr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] got;
	logic [8:0]  pin, gout, goe_n;
	logic [8:0]  ext_en = 9'h000;
	logic [8:0]  ext_val = 9'h000;
	logic [3:0]  spi_d, spi_e, spi_pin, irq;
	logic [1:0]  hv_out;
	logic [1:0]  hv_in = 2'h0;
	logic        tx, rx, dwr, tdo, last;
	logic [7:0]  o, d, m, c;
	int          n_mismatch = 0;
	int          checks = 0;
	int          n;
	logic [31:0] base [3] = '{gpfs_pkg::DAT0_ADDR, gpfs_pkg::DAT1_ADDR, gpfs_pkg::DAT2_ADDR};
	logic [7:0]  msk [3] = '{8'h1F, 8'h03, 8'h03};
	int          lsb [3] = '{0, 5, 7};
	int          irq_pin [4] = '{0, 5, 7, 8};
	always #20 mclk = ~mclk;
	always @(posedge mclk) tdat <= ~tdat;
	gpfs_top dut (
		.MCLK_IN(mclk), .RST_N_IN(rst_n), .CE_IN(ce), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .POWER_DOWN_IN(pd), .GPIO_IN(pin),
		.GPIO_OUT(gout), .GPIO_OE_N_OUT(goe_n), .SPI_DRV_IN(spi_d), .SPI_DRV_EN_IN(spi_e),
		.SPI_PIN_OUT(spi_pin), .UART_TX_IN(tx), .UART_RX_OUT(rx), .EXT_IRQ_OUT(irq),
		.HV_LINK_OUT(hv_out), .HV_LINK_IN(hv_in), .TEST_DATA_IN(tdat), .TEST_DATA_OUT(tdo),
		.DIAG_WRITE_OUT(dwr), .DIAG_READ_IN(dread), .FIXED_CLK_OUT()
	);
	gpfs_pin_model u_pins (
		.clk_in(mclk), .drv_in(gout), .oe_n_in(goe_n), .ext_en_in(ext_en), .ext_val_in(ext_val),
		.pin_out(pin), .spi_drv_out(spi_d), .spi_en_out(spi_e), .tx_out(tx)
	);
	////////////////////////////////////////
	function automatic logic [31:0] dat_exp(input logic [7:0] out_v, input logic [7:0] dir_v);
		return {8'h00, dir_v, out_v, 8'h00};
	endfunction : dat_exp
	function automatic logic [31:0] fld(input logic [8:0] v, input int p);
		return 32'((v >> lsb[p]) & msk[p]);
	endfunction : fld
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t value %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr32(input logic [31:0] a, input logic [31:0] v);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr32
	// read data stand only in the cycle after the strobe, so take them once settled inside that cycle
	task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] mk = 32'hFFFFFFFF);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdata & mk, e);
	endtask : rdchk
	task automatic settle(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : settle
	task automatic final_report;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		final_report();
	end
	////////////////////////////////////////
	initial begin
		n = $urandom(5);
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		rdchk(gpfs_pkg::CON0_ADDR, gpfs_pkg::CON0_RESET);
		rdchk(gpfs_pkg::CON1_ADDR, gpfs_pkg::CON1_RESET);
		rdchk(gpfs_pkg::CON2_ADDR, gpfs_pkg::CON2_RESET);
		rdchk(32'hFFFF0D10, 32'h0);
		rdchk(base[0] + gpfs_pkg::SET_OFS, 32'h0);
		chk({23'h0, goe_n}, 32'h1FF);
		chk({31'h0, tdo}, {31'h0, ~tdat});
		for (int p = 0; p < 3; p++) begin
			for (int i = 0; i < 4; i++) begin
				o = 8'($urandom) & msk[p];
				d = 8'($urandom) & msk[p];
				m = (i == 0) ? msk[p] : 8'($urandom) & msk[p];
				c = (i == 1) ? msk[p] : 8'($urandom) & msk[p];
				wr32(base[p], dat_exp(o, d));
				#1;
				chk(fld(gout, p) & d, 32'(o & d));
				chk(fld(~goe_n, p), 32'(d));
				wr32(base[p] + gpfs_pkg::SET_OFS, dat_exp(m, 8'h00));
				o = o | m;
				wr32(base[p] + gpfs_pkg::CLR_OFS, dat_exp(c, 8'h00));
				o = o & ~c;
				#1;
				chk(fld(gout, p) & d, 32'(o & d));
				rdchk(base[p], dat_exp(o, d), 32'hFFFFFF00);
			end
		end
		wr32(base[0], dat_exp(8'h15, 8'h1F));
		pd <= 1'b1;
		wr32(base[0], dat_exp(8'h0A, 8'h1F));
		#1;
		chk(fld(gout, 0), 32'h15);
		@(posedge mclk);
		pd <= 1'b0;
		settle(1);
		chk(fld(gout, 0), 32'h0A);
		wr32(base[0], dat_exp(8'h60, 8'h60));
		settle(1);
		chk({30'h0, hv_out}, 32'h3);
		hv_in <= 2'h2;
		rdchk(base[0], 32'h40, 32'h60);
		wr32(gpfs_pkg::CON0_ADDR, 32'h10000000);
		settle(2);
		chk({30'h0, hv_out}, 32'h0);
		wr32(base[2], dat_exp(8'h20, 8'h20));
		settle(1);
		chk({31'h0, dwr}, 32'h1);
		dread <= 1'b1;
		rdchk(base[2], 32'h10, 32'h10);
		wr32(gpfs_pkg::CON0_ADDR, 32'h10011111);
		n = 0;
		last = 1'b0;
		// 1250 cycles of 40 ns hold 128 periods of the fixed clock
		repeat (1250) begin
			settle(1);
			n += (gout[4] && !last);
			last = gout[4];
		end
		chk(32'(n >= 127 && n <= 129), 32'h1);
		chk({23'h0, goe_n} & 32'h10, 32'h0);
		// a low clock enable freezes every pin drive while the spi inputs keep moving
		@(posedge mclk);
		ce <= 1'b0;
		settle(1);
		got = {23'h0, gout};
		settle(3);
		chk({23'h0, gout}, got);
		@(posedge mclk);
		ce <= 1'b1;
		wr32(gpfs_pkg::CON1_ADDR, 32'h00000011);
		ext_en <= 9'h020;
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			ext_val[5] <= i[0];
			#1;
			chk({31'h0, rx}, 32'(i[0]));
		end
		chk({23'h0, goe_n} & 32'h20, 32'h20);
		wr32(gpfs_pkg::CON1_ADDR, gpfs_pkg::CON1_RESET);
		wr32(gpfs_pkg::CON0_ADDR, gpfs_pkg::CON0_RESET);
		for (int p = 0; p < 3; p++) wr32(base[p], 32'h0);
		ext_en <= 9'h1A1;
		ext_val <= 9'h000;
		settle(2);
		chk({28'h0, irq}, 32'h0);
		chk({28'h0, spi_pin}, 32'hE);
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			ext_val[irq_pin[i]] <= 1'b1;
			settle(3);
			chk({28'h0, irq}, 32'h1 << i);
			@(posedge mclk);
			ext_val[irq_pin[i]] <= 1'b0;
		end
		@(posedge mclk);
		ext_en <= 9'h000;
		settle(2);
		chk({28'h0, irq}, 32'hF);
		wr32(gpfs_pkg::CON0_ADDR, 32'h10000000);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rdchk(gpfs_pkg::CON0_ADDR, gpfs_pkg::CON0_RESET);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
